/* pkg/hfp_pkg.sv */
// Constants shared by the flash erase, program and protection host controller
package hfp_pkg;

    // User command codes on the command port
    localparam logic [2:0] OP_SECT_ERASE = 3'h0;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h1;
    localparam logic [2:0] OP_PROG_BUF   = 3'h2;
    localparam logic [2:0] OP_PROT_EN    = 3'h3;
    localparam logic [2:0] OP_PROT_DIS   = 3'h4;

    // Opcode bytes sent on the serial input
    localparam logic [7:0] OPC_SECT_ERASE = 8'h7C;
    localparam logic [7:0] OPC_PROG_BUF1  = 8'h82;
    localparam logic [7:0] OPC_PROG_BUF2  = 8'h85;
    localparam logic [7:0] OPC_CHIP_B1    = 8'hC7;
    localparam logic [7:0] OPC_CHIP_B2    = 8'h94;
    localparam logic [7:0] OPC_CHIP_B3    = 8'h80;
    localparam logic [7:0] OPC_CHIP_B4    = 8'h9A;
    localparam logic [7:0] OPC_PROT_B1    = 8'h3D;
    localparam logic [7:0] OPC_PROT_B2    = 8'h2A;
    localparam logic [7:0] OPC_PROT_B3    = 8'h7F;
    localparam logic [7:0] OPC_PROT_EN_B4 = 8'hA9;
    localparam logic [7:0] OPC_PROT_DI_B4 = 8'h9A;

    // Header length in bytes, for every command
    localparam logic [2:0] HDR_BYTES = 3'h4;

    // Address field widths
    localparam int PAGE_W     = 13;
    localparam int BUF_ADDR_W = 11;

    // Timing in nanoseconds and the derived cycle counts (least: round up)
    localparam int CLK_NS      = 8;
    localparam int SCK_HALF_NS = 16;
    localparam int CS_HI_NS    = 50;
    localparam int SETTLE_NS   = 200;
    localparam logic [7:0] SCK_HALF_CYC =
        8'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] CS_HI_CYC =
        8'((CS_HI_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SETTLE_CYC =
        8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

    // Default busy time-out in system clock cycles
    localparam logic [31:0] BUSY_LIMIT_DEF = 32'h2FAF_0800;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LOAD  = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_CSHI  = 5'b01000,
        ST_WAIT  = 5'b10000
    } hfp_state_e;

endpackage : hfp_pkg

/* rtl/hfp_sync3.sv */
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/10ps

module hfp_sync3 (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Pin side and filtered level
    input  wire logic pin_in,
    output logic      level_out
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;

    // Chain of three; the first stage feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
        end else begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // Accept a change only once the second and third stages agree
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b0;
        end else if (stage2_r == stage3_r) begin
            level_out <= stage3_r;
        end
    end

endmodule : hfp_sync3

/* rtl/hfp_ctrl.sv */
// Host controller for flash sector/chip erase, page program, protection
`timescale 1ns/10ps

module hfp_ctrl #(
    parameter logic [31:0] BUSY_LIMIT = hfp_pkg::BUSY_LIMIT_DEF
) (
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // Command port
    input  wire logic        cmd_valid_in,
    input  wire logic [2:0]  cmd_op_in,
    input  wire logic        bin_page_in,
    input  wire logic [12:0] page_in,
    input  wire logic        buf_sel_in,
    input  wire logic [10:0] buf_addr_in,
    input  wire logic        wp_assert_in,
    output logic             cmd_ready_out,
    output logic             busy_out,
    output logic             done_out,
    output logic             err_out,
    output logic             flash_ready_out,
    // Program data stream
    input  wire logic        wr_valid_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_last_in,
    output logic             wr_ready_out,
    // Flash pins
    input  wire logic        flash_ready_in,
    output logic             cs_n_out,
    output logic             sck_out,
    output logic             mosi_out,
    output logic             wp_n_out
);

    hfp_pkg::hfp_state_e state_r;
    hfp_pkg::hfp_state_e state_nxt;

    logic [31:0] hdr_r;
    logic [2:0]  op_r;
    logic [2:0]  nhdr_r;
    logic [7:0]  shreg_r;
    logic [2:0]  bit_r;
    logic [7:0]  div_r;
    logic [7:0]  cnt_r;
    logic [31:0] wait_r;
    logic        last_r;
    logic        sck_r;
    logic        wr_ready_r;
    logic        rdy_s;

    // Ready/busy pin enters through the three-stage filter
    hfp_sync3 u_rdy_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .pin_in     (flash_ready_in),
        .level_out  (rdy_s)
    );

    // Sector erase page: keep bits 12..3 in sector 0, bits 12..8 above
    wire        sect0     = (page_in[12:8] == 5'h00);
    wire [12:0] sect_page = sect0 ? {page_in[12:3], 3'h0}
                                  : {page_in[12:8], 8'h00};

    // Three address bytes for each page layout
    wire [23:0] addr_se_std = {sect_page, 11'h000};
    wire [23:0] addr_se_bin = {1'b0, sect_page, 10'h000};
    wire [23:0] addr_pg_std = {page_in, buf_addr_in};
    wire [23:0] addr_pg_bin = {1'b0, page_in, buf_addr_in[9:0]};
    wire [23:0] addr_se = bin_page_in ? addr_se_bin : addr_se_std;
    wire [23:0] addr_pg = bin_page_in ? addr_pg_bin : addr_pg_std;

    // Program opcode picks the buffer
    wire [7:0] opc_pg = buf_sel_in ? hfp_pkg::OPC_PROG_BUF2
                                   : hfp_pkg::OPC_PROG_BUF1;

    // Four-byte headers for every command
    wire [31:0] hdr_se   = {hfp_pkg::OPC_SECT_ERASE, addr_se};
    wire [31:0] hdr_pg   = {opc_pg, addr_pg};
    wire [31:0] hdr_ce   = {hfp_pkg::OPC_CHIP_B1, hfp_pkg::OPC_CHIP_B2,
                            hfp_pkg::OPC_CHIP_B3,
                            hfp_pkg::OPC_CHIP_B4};
    wire [23:0] prot_pre = {hfp_pkg::OPC_PROT_B1, hfp_pkg::OPC_PROT_B2,
                            hfp_pkg::OPC_PROT_B3};
    wire [31:0] hdr_pe   = {prot_pre, hfp_pkg::OPC_PROT_EN_B4};
    wire [31:0] hdr_pd   = {prot_pre, hfp_pkg::OPC_PROT_DI_B4};

    // Command decode; disable under write protect would be ignored anyway
    wire op_se   = (cmd_op_in == hfp_pkg::OP_SECT_ERASE);
    wire op_ce   = (cmd_op_in == hfp_pkg::OP_CHIP_ERASE);
    wire op_pg   = (cmd_op_in == hfp_pkg::OP_PROG_BUF);
    wire op_pe   = (cmd_op_in == hfp_pkg::OP_PROT_EN);
    wire op_pd   = (cmd_op_in == hfp_pkg::OP_PROT_DIS);
    wire op_ok   = op_se | op_ce | op_pg | op_pe | (op_pd & wp_n_out);
    wire [31:0] hdr_sel = op_se ? hdr_se :
                          op_ce ? hdr_ce :
                          op_pg ? hdr_pg :
                          op_pe ? hdr_pe : hdr_pd;

    // Handshake terms
    wire take     = cmd_ready_out & cmd_valid_in;
    wire accept   = take & op_ok;
    wire reject   = take & ~op_ok;
    wire in_hdr   = (nhdr_r != 3'h0);
    wire data_ph  = (op_r == hfp_pkg::OP_PROG_BUF) & ~last_r;
    wire wr_take  = wr_ready_r & wr_valid_in;
    wire tick     = (div_r == hfp_pkg::SCK_HALF_CYC - 8'h01);
    wire fall     = tick & sck_r;
    wire byte_end = fall & (bit_r == 3'h7);
    wire prot_op  = (op_r == hfp_pkg::OP_PROT_EN) |
                    (op_r == hfp_pkg::OP_PROT_DIS);
    wire cs_done  = (cnt_r == hfp_pkg::CS_HI_CYC - 8'h01);
    wire settled  = (cnt_r >= hfp_pkg::SETTLE_CYC - 8'h01);
    wire timeout  = (wait_r == BUSY_LIMIT);
    wire wait_end = (settled & rdy_s) | timeout;

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hfp_pkg::ST_IDLE: begin
                if (accept) begin
                    state_nxt = hfp_pkg::ST_LOAD;
                end
            end
            hfp_pkg::ST_LOAD: begin
                if (in_hdr || wr_take) begin
                    state_nxt = hfp_pkg::ST_SHIFT;
                end else if (!data_ph) begin
                    // Header always complete before the rise
                    state_nxt = hfp_pkg::ST_CSHI;
                end
            end
            hfp_pkg::ST_SHIFT: begin
                if (byte_end) begin
                    state_nxt = hfp_pkg::ST_LOAD;
                end
            end
            hfp_pkg::ST_CSHI: begin
                if (cs_done) begin
                    state_nxt = prot_op ? hfp_pkg::ST_IDLE
                                        : hfp_pkg::ST_WAIT;
                end
            end
            hfp_pkg::ST_WAIT: begin
                if (wait_end) begin
                    state_nxt = hfp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_r <= hfp_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Latched command and header bytes still to send
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            op_r   <= 3'h0;
            hdr_r  <= 32'h0000_0000;
            nhdr_r <= 3'h0;
        end else if (accept) begin
            op_r   <= cmd_op_in;
            hdr_r  <= hdr_sel;
            nhdr_r <= hfp_pkg::HDR_BYTES;
        end else if (state_r == hfp_pkg::ST_LOAD && in_hdr) begin
            hdr_r  <= {hdr_r[23:0], 8'h00};
            nhdr_r <= nhdr_r - 3'h1;
        end
    end

    // Data stream ready: raised in a data load, dropped on a take
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wr_ready_r <= 1'b0;
        end else begin
            wr_ready_r <= (state_r == hfp_pkg::ST_LOAD) & ~in_hdr &
                          data_ph & ~wr_take;
        end
    end

    // Last data byte seen; ends the program data phase
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            last_r <= 1'b0;
        end else if (accept) begin
            last_r <= 1'b0;
        end else if (wr_take) begin
            last_r <= wr_last_in;
        end
    end

    // Shift register; its top bit drives the serial input pin
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            shreg_r <= 8'h00;
        end else if (state_r == hfp_pkg::ST_LOAD && in_hdr) begin
            shreg_r <= hdr_r[31:24];
        end else if (wr_take) begin
            shreg_r <= wr_data_in;
        end else if (state_r == hfp_pkg::ST_SHIFT && fall) begin
            shreg_r <= {shreg_r[6:0], 1'b0};
        end
    end

    // Serial clock divider; mode 0, data moves on the falling edge
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            div_r <= 8'h00;
            sck_r <= 1'b0;
            bit_r <= 3'h0;
        end else if (state_r == hfp_pkg::ST_SHIFT) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            sck_r <= tick ? ~sck_r : sck_r;
            bit_r <= fall ? bit_r + 3'h1 : bit_r;
        end else begin
            div_r <= 8'h00;
            sck_r <= 1'b0;
            bit_r <= 3'h0;
        end
    end

    // Per-state cycle counter for chip select high and busy settle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cnt_r <= 8'h00;
        end else if (state_nxt != state_r) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // Busy time-out counter, runs only while waiting on the device
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wait_r <= 32'h0000_0000;
        end else if (state_r != hfp_pkg::ST_WAIT) begin
            wait_r <= 32'h0000_0000;
        end else if (!timeout) begin
            wait_r <= wait_r + 32'h0000_0001;
        end
    end

    // Chip select low across the whole frame, high once it is complete
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cs_n_out <= 1'b1;
        end else begin
            cs_n_out <= ~((state_nxt == hfp_pkg::ST_LOAD) |
                          (state_nxt == hfp_pkg::ST_SHIFT));
        end
    end

    // Write protect follows the user level only between operations
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wp_n_out <= 1'b1;
        end else if (state_r == hfp_pkg::ST_IDLE) begin
            wp_n_out <= ~wp_assert_in;
        end
    end

    // User status outputs
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cmd_ready_out   <= 1'b0;
            busy_out        <= 1'b0;
            done_out        <= 1'b0;
            err_out         <= 1'b0;
            flash_ready_out <= 1'b0;
        end else begin
            cmd_ready_out   <= (state_nxt == hfp_pkg::ST_IDLE) & ~take;
            busy_out        <= (state_nxt != hfp_pkg::ST_IDLE);
            done_out        <= (state_r != hfp_pkg::ST_IDLE) &
                               (state_nxt == hfp_pkg::ST_IDLE);
            err_out         <= reject |
                               ((state_r == hfp_pkg::ST_WAIT) & timeout);
            flash_ready_out <= rdy_s;
        end
    end

    // Pins and stream ready come straight from flip-flops
    assign sck_out      = sck_r;
    assign mosi_out     = shreg_r[7];
    assign wr_ready_out = wr_ready_r;

endmodule : hfp_ctrl

/* sim/hfp_flash_model.sv */
// Behavioural model of the serial flash device behind the controller
`timescale 1ns/10ps

module hfp_flash_model (
    // Flash pins
    input  wire logic   cs_n_in,
    input  wire logic   sck_in,
    input  wire logic   mosi_in,
    input  wire logic   wp_n_in,
    output logic        ready_out,
    // Test control and observation
    input  wire logic   slow_in,
    output logic [31:0] hdr_out,
    output logic [7:0]  byte_out,
    output int          nbits_out,
    output int          frames_out,
    output int          erased_out,
    output logic        prot_en_out
);
    // Protection register, one byte a sector; 00H leaves a sector open
    logic [7:0] prot_reg [32];

    // Power-up state: ready, software protection off
    initial begin
        ready_out = 1'b1;
        prot_en_out = 1'b0;
        hdr_out = 32'h0000_0000;
        byte_out = 8'h00;
        nbits_out = 0;
        frames_out = 0;
        erased_out = 0;
        foreach (prot_reg[s]) prot_reg[s] = 8'h00;
    end

    // A frame opens on chip select fall
    always @(negedge cs_n_in) begin
        nbits_out = 0;
    end

    // Shift in on serial clock rise: header first, then data
    always @(posedge sck_in) begin
        if (!cs_n_in) begin
            if (nbits_out < 32)
                hdr_out = {hdr_out[30:0], mosi_in};
            else
                byte_out = {byte_out[6:0], mosi_in};
            nbits_out = nbits_out + 1;
        end
    end

    // Act on chip select rise; a short frame starts nothing
    always @(posedge cs_n_in) begin
        frames_out = frames_out + 1;
        if (nbits_out >= 32) begin
            // Chip erase skips sectors guarded while protection is on
            if (hdr_out == 32'hC794_809A) begin
                erased_out = 0;
                for (int s = 0; s < 32; s++)
                    if (!prot_en_out || prot_reg[s] != 8'hFF)
                        erased_out = erased_out + 1;
            end
            if (hdr_out[31:24] == 8'h7C || hdr_out[31:24] == 8'h82 ||
                hdr_out[31:24] == 8'h85 || hdr_out == 32'hC794_809A) begin
                ready_out = 1'b0;
                #(slow_in ? 3000 : 400);
                ready_out = 1'b1;
            end
            if (hdr_out == 32'h3D2A_7FA9)
                prot_en_out = 1'b1;
            if (hdr_out == 32'h3D2A_7F9A && wp_n_in !== 1'b0)
                prot_en_out = 1'b0;
        end
    end
endmodule : hfp_flash_model

/* sim/hfp_ctrl_properties.sv */
// Concurrent checks on the host controller's ports
`timescale 1ns/10ps

module hfp_ctrl_properties (
    // Clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    // Command port
    input wire logic       cmd_valid_in,
    input wire logic [2:0] cmd_op_in,
    input wire logic       cmd_ready_out,
    input wire logic       done_out,
    input wire logic       err_out,
    input wire logic       busy_out,
    input wire logic       flash_ready_out,
    // Data stream
    input wire logic       wr_valid_in,
    input wire logic       wr_last_in,
    input wire logic       wr_ready_out,
    // Flash pins
    input wire logic       cs_n_out,
    input wire logic       sck_out,
    input wire logic       mosi_out,
    input wire logic       wp_n_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // Taken commands and the ones that must be refused
    wire take = cmd_valid_in && cmd_ready_out;
    wire bad  = cmd_op_in > 3'h4 || (cmd_op_in == 3'h4 && !wp_n_out);

    property p_take; take |=> !cmd_ready_out; endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_ref_err; take && bad |-> ##[1:2] err_out; endproperty
    a_ref_err: assert property (p_ref_err) else $error("no refusal");
    property p_ref_pins; take && bad |=> cs_n_out [*8]; endproperty
    a_ref_pins: assert property (p_ref_pins) else $error("pin activity");
    property p_done; done_out |-> cmd_ready_out ##1 !done_out; endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_wp_hold; busy_out && $past(busy_out) |-> $stable(wp_n_out);
    endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("wp moved");
    property p_done_rdy; done_out && !err_out |-> flash_ready_out; endproperty
    a_done_rdy: assert property (p_done_rdy) else $error("done early");
    property p_cs_gap; $rose(cs_n_out) |=> cs_n_out [*6]; endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("cs gap short");
    property p_sck_hi; $rose(sck_out) |=> sck_out ##1 !sck_out; endproperty
    a_sck_hi: assert property (p_sck_hi) else $error("sck high width");
    property p_mosi; sck_out |-> $stable(mosi_out); endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved");
    property p_wr; wr_valid_in && wr_ready_out |=> !wr_ready_out; endproperty
    a_wr: assert property (p_wr) else $error("ready after byte");

    // Main scenarios reached
    c_refuse: cover property (take && bad ##1 err_out);
    c_frame: cover property ($rose(cs_n_out));
    c_last: cover property (wr_valid_in && wr_ready_out && wr_last_in);
endmodule : hfp_ctrl_properties

bind hfp_ctrl hfp_ctrl_properties u_props (.clk_sys_in, .rst_n_in,
    .cmd_valid_in, .cmd_op_in, .cmd_ready_out, .done_out, .err_out,
    .busy_out, .flash_ready_out, .wr_valid_in, .wr_last_in, .wr_ready_out,
    .cs_n_out, .sck_out, .mosi_out, .wp_n_out);

/* sim/test_flash_erase_program_protect.sv */
// Self-checking bench for the flash erase, program and protection controller
`timescale 1ns/10ps

module test_flash_erase_program_protect;
    logic        clk, rst_n, cmd_valid, bin_page, buf_sel, wp_assert, slow;
    logic        wr_valid, wr_last, got_err, cmd_ready, busy, done, err;
    logic        fl_rdy, wr_ready, flash_rdy, cs_n, sck, mosi, wp_n, prot_en;
    logic [2:0]  cmd_op;
    logic [12:0] page, pg;
    logic [10:0] buf_addr, st_addr;
    logic [7:0]  wr_data, exp_byte, last_byte;
    logic [31:0] seed, hdr;
    logic [12:0] corner [4] = '{13'h0000, 13'h000F, 13'h0107, 13'h1FFF};
    int          fail_count, num_checks, nbits, frames, f0, i, nb, erased;

    // Controller with a short busy limit
    hfp_ctrl #(.BUSY_LIMIT(32'h0000_07D0)) dut (.clk_sys_in(clk),
        .rst_n_in(rst_n), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
        .bin_page_in(bin_page), .page_in(page), .buf_sel_in(buf_sel),
        .buf_addr_in(buf_addr), .wp_assert_in(wp_assert),
        .cmd_ready_out(cmd_ready), .busy_out(busy), .done_out(done),
        .err_out(err), .flash_ready_out(fl_rdy), .wr_valid_in(wr_valid),
        .wr_data_in(wr_data), .wr_last_in(wr_last), .wr_ready_out(wr_ready),
        .flash_ready_in(flash_rdy), .cs_n_out(cs_n), .sck_out(sck),
        .mosi_out(mosi), .wp_n_out(wp_n));

    // Device model on the flash pins
    hfp_flash_model u_flash (.cs_n_in(cs_n), .sck_in(sck), .mosi_in(mosi),
        .wp_n_in(wp_n), .ready_out(flash_rdy), .slow_in(slow),
        .hdr_out(hdr), .byte_out(last_byte), .nbits_out(nbits),
        .frames_out(frames), .erased_out(erased), .prot_en_out(prot_en));

    // System clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Next value of the xorshift sequence
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Header the device should receive for a command
    function automatic logic [31:0] exp_hdr(input logic [2:0] op,
        input logic bl, input logic [12:0] p, input logic bs,
        input logic [10:0] ba);
        logic [12:0] m;
        m = (p[12:8] == 5'h00) ? {p[12:3], 3'h0} : {p[12:8], 8'h00};
        case (op)
            3'h0: return bl ? {8'h7C, 1'b0, m, 10'h000} : {8'h7C, m, 11'h000};
            3'h1: return 32'hC794_809A;
            3'h2: return {bs ? 8'h85 : 8'h82, bl ? {1'b0, p, ba[9:0]} : {p, ba}};
            3'h3: return 32'h3D2A_7FA9;
            default: return 32'h3D2A_7F9A;
        endcase
    endfunction : exp_hdr

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Report and end the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Issue one command, stream n bytes, wait for done or refusal
    task automatic run(input logic [2:0] op, input logic bl,
        input logic [12:0] p, input logic bs, input logic [10:0] ba,
        input int n, input logic sl);
        int k;
        int w;
        logic exp_busy;
        exp_busy = !(op > 3'h4 || (op == 3'h4 && wp_assert));
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        bin_page <= bl;
        page <= p;
        buf_sel <= bs;
        buf_addr <= ba;
        slow <= sl;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        cmd_valid <= 1'b0;
        for (k = 0; k < n; k++) begin
            exp_byte = 8'(rnd());
            wr_valid <= 1'b1;
            wr_data <= exp_byte;
            wr_last <= (k == n - 1);
            for (w = 0; w < 200; w++) begin
                @(posedge clk);
                if (wr_ready === 1'b1) break;
            end
        end
        wr_valid <= 1'b0;
        wr_last <= 1'b0;
        got_err = 1'b0;
        for (k = 0; k < 3000; k++) begin
            @(posedge clk);
            if (k == 0) check("busy", busy, exp_busy);
            if (err === 1'b1) got_err = 1'b1;
            if (done === 1'b1 || err === 1'b1) break;
        end
        // Keep the pins quiet for a while after a refused command
        if (got_err) repeat (8) @(posedge clk);
        check("finished", k < 3000, 1'b1);
    endtask : run

    // Hang guard
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    // Main sequence
    initial begin
        seed = 32'h0000_0017;
        fail_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 3'h0;
        bin_page = 1'b0;
        page = 13'h0000;
        buf_sel = 1'b0;
        buf_addr = 11'h000;
        wp_assert = 1'b0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        wr_last = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("idle pins", {cs_n, sck, wp_n}, 3'h5);
        for (i = 0; i < 10; i++) begin
            pg = (i < 4) ? corner[i] : 13'(rnd());
            run(3'h0, i[0], pg, 1'b0, 11'h000, 0, i[1]);
            check("sect hdr", hdr, exp_hdr(3'h0, i[0], pg, 1'b0, 11'h000));
            check("sect bits", nbits, 32);
            check("sect err", got_err, 1'b0);
        end
        for (i = 0; i < 2; i++) begin
            run(3'h1, i[0], 13'h0000, 1'b0, 11'h000, 0, i[0]);
            check("chip hdr", hdr, 32'hC794_809A);
            check("chip bits", nbits, 32);
            check("chip sectors", erased, 32);
        end
        for (i = 0; i < 4; i++) begin
            nb = 1 + int'(rnd() % 32'h4);
            pg = 13'(rnd());
            st_addr = (i == 0) ? 11'h7FF : 11'(rnd());
            run(3'h2, i[1], pg, i[0], st_addr, nb, i[0]);
            check("prog hdr", hdr, exp_hdr(3'h2, i[1], pg, i[0], st_addr));
            check("prog bits", nbits, 32 + 8 * nb);
            check("prog byte", last_byte, exp_byte);
        end
        run(3'h3, 1'b0, 13'h0000, 1'b0, 11'h000, 0, 1'b0);
        check("prot on", prot_en, 1'b1);
        wp_assert <= 1'b1;
        repeat (4) @(posedge clk);
        check("wp pin", wp_n, 1'b0);
        f0 = frames;
        run(3'h4, 1'b0, 13'h0000, 1'b0, 11'h000, 0, 1'b0);
        check("dis refused", {got_err, prot_en}, 2'h3);
        check("dis frames", frames, f0);
        wp_assert <= 1'b0;
        repeat (4) @(posedge clk);
        run(3'h4, 1'b0, 13'h0000, 1'b0, 11'h000, 0, 1'b0);
        check("prot off", prot_en, 1'b0);
        f0 = frames;
        run(3'h5, 1'b0, 13'h0000, 1'b0, 11'h000, 0, 1'b0);
        check("bad op", {got_err, 31'(frames - f0)}, 32'h8000_0000);
        fork
            run(3'h1, 1'b0, 13'h0000, 1'b0, 11'h000, 0, 1'b1);
            begin
                repeat (200) @(posedge clk);
                wp_assert <= 1'b1;
                repeat (4) @(posedge clk);
                check("wp held", wp_n, 1'b1);
            end
        join
        repeat (4) @(posedge clk);
        check("wp after", wp_n, 1'b0);
        wrap_up();
    end
endmodule : test_flash_erase_program_protect
